// ---- design/uart_channel_baud_irq.v ----
// Purpose: One serial channel with baud timer, modes and interrupt request
// Assumes: Control bits arrive as plain ports from the owner logic
// Notes:   External clock and serial inputs pass a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "uart_channel_defs.vh"
module uart_channel_baud_irq #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = 5
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        rx_serial,
  output wire        tx_serial,
  output reg         rts_n_q,
  input  wire        cts_n,
  input  wire        external_timer_input,
  input  wire        tx_enable,
  input  wire        rx_enable,
  input  wire [1:0]  data_bits_sel,
  input  wire [1:0]  parity_mode,
  input  wire        parity_force_val,
  input  wire        multidrop_mode,
  input  wire [5:0]  stop_len16,
  input  wire        stop_two_x1,
  input  wire [1:0]  channel_mode,
  input  wire        send_break,
  input  wire        cts_enable,
  input  wire [1:0]  rts_control,
  input  wire        rts_manual,
  input  wire        rx_clk_ext,
  input  wire        tx_clk_ext,
  input  wire        ext_x1,
  input  wire [7:0]  baud_preload_first,
  input  wire [7:0]  baud_preload_second,
  input  wire [7:0]  tx_data,
  input  wire        tx_valid,
  output wire        tx_ready,
  output wire        tx_empty,
  input  wire        rx_read,
  output reg  [7:0]  rx_data_q,
  output reg  [2:0]  rx_err_q,
  output wire        rx_ready,
  output wire        rx_fifo_full,
  output reg         overrun_q,
  input  wire        overrun_clr,
  output reg         break_active_q,
  input  wire [3:0]  interrupt_mask_reg,
  input  wire [3:0]  status_clr,
  output wire [3:0]  interrupt_status_reg,
  output wire        irq_n,
  input  wire        iack,
  input  wire        vector_enable,
  input  wire [7:0]  interrupt_vector_reg,
  output reg  [7:0]  iack_vector_q,
  output reg         iack_vector_valid_q
);
  localparam S_IDLE  = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA  = 3'h2;
  localparam S_PAR   = 3'h3;
  localparam S_STOP  = 3'h4;

  // Synchronisers
  reg [1:0] ext_s_q, rxd_s_q, cts_s_q;
  reg       ext_prev_q, cts_prev_q, rx_prev_q;
  wire      rx_line;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s_q    <= 2'h0;
      rxd_s_q    <= 2'h3;
      cts_s_q    <= 2'h3;
      ext_prev_q <= 1'b0;
      cts_prev_q <= 1'b1;
      rx_prev_q  <= 1'b1;
    end else begin
      ext_s_q    <= {ext_s_q[0], external_timer_input};
      rxd_s_q    <= {rxd_s_q[0], rx_serial};
      cts_s_q    <= {cts_s_q[0], cts_n};
      ext_prev_q <= ext_s_q[1];
      cts_prev_q <= cts_s_q[1];
      rx_prev_q  <= rx_line;
    end
  end
  wire ext_rise = ext_s_q[1] && !ext_prev_q;
  wire ext_fall = !ext_s_q[1] && ext_prev_q;
  wire line_in  = rxd_s_q[1];

  // Baud timer
  reg [7:0]  presc_q;
  reg [15:0] timer_q;
  reg        half_q;
  wire       presc_tick = (presc_q == `PRESCALE_DIV - 1);
  wire       timer_zero = presc_tick && (timer_q == 16'h0000);
  wire       timer_tick = timer_zero && half_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q <= 8'h00;
      timer_q <= 16'h0000;
      half_q  <= 1'b0;
    end else begin
      presc_q <= presc_tick ? 8'h00 : presc_q + 8'h01;
      if (timer_zero) begin
        timer_q <= {baud_preload_first, baud_preload_second};
        half_q  <= !half_q;
      end else if (presc_tick) begin
        timer_q <= timer_q - 16'h0001;
      end
    end
  end
  wire tx_t16 = tx_clk_ext ? ext_rise : timer_tick;
  wire rx_t16 = rx_clk_ext ? ext_rise : timer_tick;
  wire tx_x1  = tx_clk_ext && ext_x1;
  wire rx_x1  = rx_clk_ext && ext_x1;

  // Character format
  wire [3:0] nbits   = {2'b00, data_bits_sel} + 4'h5;
  wire [7:0] dmask   = 8'hff >> (4'h8 - nbits);
  wire       has_par = multidrop_mode || (parity_mode != `PAR_NONE);

  // Transmitter
  reg [2:0] tx_st_q;
  reg [7:0] hold_q, shift_q;
  reg       hold_full_q, txo_q, tx_par_q, rts_hold_q;
  reg [3:0] tx_ph_q, tx_cnt_q;
  reg [5:0] tx_stop_q;
  wire      tx_step = tx_x1 ? ext_fall : (tx_t16 && tx_ph_q == `X16_LAST);
  wire      cts_ok  = !cts_enable || !cts_s_q[1];
  wire      stop_u  = tx_x1 ? ext_fall : tx_t16;
  wire [5:0] stop_n = tx_x1 ? (stop_two_x1 ? 6'h02 : 6'h01) : stop_len16;
  assign tx_ready = tx_enable && !hold_full_q;
  assign tx_empty = !hold_full_q && (tx_st_q == S_IDLE);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q     <= S_IDLE;
      hold_q      <= 8'h00;
      shift_q     <= 8'h00;
      hold_full_q <= 1'b0;
      txo_q       <= `RST_LINE;
      tx_par_q    <= 1'b0;
      tx_ph_q     <= 4'h0;
      tx_cnt_q    <= 4'h0;
      tx_stop_q   <= 6'h00;
    end else begin
      if (tx_valid && tx_ready) begin
        hold_q      <= tx_data;
        hold_full_q <= 1'b1;
      end
      if (tx_t16) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      case (tx_st_q)
        S_IDLE: begin
          txo_q <= 1'b1;
          if (hold_full_q && tx_enable && cts_ok && tx_step) begin
            shift_q     <= hold_q & dmask;
            hold_full_q <= 1'b0;
            tx_par_q    <= multidrop_mode ? parity_force_val
                         : (parity_mode == `PAR_FORCE) ? parity_force_val
                         : ((^(hold_q & dmask)) ^ (parity_mode == `PAR_ODD));
            txo_q       <= 1'b0;
            tx_cnt_q    <= 4'h0;
            tx_st_q     <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_step) begin
            txo_q    <= shift_q[0];
            shift_q  <= {1'b0, shift_q[7:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == nbits) begin
              txo_q   <= has_par ? tx_par_q : 1'b1;
              tx_st_q <= has_par ? S_PAR : S_STOP;
            end
            tx_stop_q <= 6'h00;
          end
        end
        S_PAR: begin
          if (tx_step) begin
            txo_q   <= 1'b1;
            tx_st_q <= S_STOP;
          end
        end
        default: begin
          if (stop_u) begin
            tx_stop_q <= tx_stop_q + 6'h01;
          end
          if (tx_stop_q + 6'h01 >= stop_n) begin
            tx_ph_q <= `X16_LAST;
            tx_st_q <= S_IDLE;
          end
        end
      endcase
    end
  end
  wire tx_bits = (tx_st_q == S_IDLE && !tx_enable) ? 1'b1 : txo_q;
  assign tx_serial = (channel_mode == `CH_LOCAL_LOOP) ? 1'b1
                   : (channel_mode == `CH_ECHO ||
                      channel_mode == `CH_REMOTE_LOOP) ? line_in
                   : send_break ? 1'b0 : tx_bits;
  assign rx_line = (channel_mode == `CH_LOCAL_LOOP) ? tx_bits : line_in;

  // Receiver
  reg [2:0]  rx_st_q;
  reg [3:0]  rx_ph_q, rx_cnt_q;
  reg [7:0]  rx_sh_q;
  reg        rx_par_q, rx_ad_q, rx_push_q, rx_any1_q;
  reg [`RW_WIDTH-1:0] rx_word_q;
  wire       rx_on     = rx_enable && (channel_mode != `CH_REMOTE_LOOP);
  wire       rx_sample = rx_x1 ? ext_rise : (rx_t16 && rx_ph_q == `X16_MID);
  wire       fifo_in_ready, fifo_out_valid;
  wire [`RW_WIDTH-1:0] fifo_out;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_q        <= S_IDLE;
      rx_ph_q        <= 4'h0;
      rx_cnt_q       <= 4'h0;
      rx_sh_q        <= 8'h00;
      rx_par_q       <= 1'b0;
      rx_ad_q        <= 1'b0;
      rx_any1_q      <= 1'b0;
      rx_push_q      <= 1'b0;
      rx_word_q      <= {`RW_WIDTH{1'b0}};
      break_active_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      if (rx_t16) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
      if (break_active_q && rx_line) begin
        break_active_q <= 1'b0;
      end
      case (rx_st_q)
        S_IDLE: begin
          rx_ph_q <= 4'h0;
          if (rx_on && !break_active_q && !rx_line && (rx_prev_q || rx_x1)) begin
            rx_st_q <= S_START;
          end
        end
        S_START: begin
          if (rx_sample) begin
            rx_st_q   <= rx_line ? S_IDLE : S_DATA;
            rx_cnt_q  <= 4'h0;
            rx_par_q  <= 1'b0;
            rx_any1_q <= 1'b0;
          end
        end
        S_DATA: begin
          if (rx_sample) begin
            rx_sh_q   <= {rx_line, rx_sh_q[7:1]};
            rx_par_q  <= rx_par_q ^ rx_line;
            rx_any1_q <= rx_any1_q | rx_line;
            rx_cnt_q  <= rx_cnt_q + 4'h1;
            if (rx_cnt_q + 4'h1 == nbits) begin
              rx_st_q <= has_par ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (rx_sample) begin
            rx_ad_q   <= rx_line;
            rx_any1_q <= rx_any1_q | rx_line;
            rx_par_q  <= (parity_mode == `PAR_FORCE) ? (rx_line != parity_force_val)
                       : (rx_par_q ^ rx_line ^ (parity_mode == `PAR_ODD));
            rx_st_q   <= S_STOP;
          end
        end
        default: begin
          if (rx_sample) begin
            rx_word_q[7:0]     <= rx_sh_q >> (4'h8 - nbits);
            rx_word_q[`RW_PE]  <= multidrop_mode ? rx_ad_q
                                : has_par && rx_par_q;
            rx_word_q[`RW_FE]  <= !rx_line;
            rx_word_q[`RW_RB]  <= !rx_line && !rx_any1_q;
            if (!rx_line && !rx_any1_q) begin
              break_active_q <= 1'b1;
            end
            rx_push_q <= !multidrop_mode || rx_ad_q;
            rx_st_q   <= S_IDLE;
          end
        end
      endcase
    end
  end

  char_fifo #(
    .WIDTH (`RW_WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (rx_word_q),
    .in_valid  (rx_push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (rx_read),
    .full      (rx_fifo_full)
  );
  assign rx_ready = fifo_out_valid;

  // Read data, overrun, handshake lines, status
  reg  [3:0] ist_q;
  reg        brk_prev_q;
  wire [3:0] ist_set;
  assign ist_set[`IST_TX_READY]  = 1'b0;
  assign ist_set[`IST_RX_READY]  = 1'b0;
  assign ist_set[`IST_BREAK_CHG] = break_active_q != brk_prev_q;
  assign ist_set[`IST_CTS_CHG]   = cts_s_q[1] != cts_prev_q;
  assign interrupt_status_reg = {ist_q[3:2], fifo_out_valid, tx_ready};
  assign irq_n = ~|(interrupt_status_reg & interrupt_mask_reg);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_q           <= 8'h00;
      rx_err_q            <= 3'h0;
      overrun_q           <= 1'b0;
      ist_q               <= `RST_STATUS;
      brk_prev_q          <= 1'b0;
      rts_n_q             <= 1'b1;
      rts_hold_q          <= 1'b0;
      iack_vector_q       <= 8'h00;
      iack_vector_valid_q <= 1'b0;
    end else begin
      brk_prev_q <= break_active_q;
      if (rx_read && fifo_out_valid) begin
        rx_data_q <= fifo_out[7:0];
        rx_err_q  <= fifo_out[`RW_RB:`RW_PE];
      end
      if (rx_push_q && !fifo_in_ready) begin
        overrun_q <= 1'b1;
      end else if (overrun_clr) begin
        overrun_q <= 1'b0;
      end
      ist_q <= ist_set | (ist_q & ~status_clr);
      if (tx_st_q != S_IDLE) begin
        rts_hold_q <= 1'b1;
      end else if (tx_empty) begin
        rts_hold_q <= 1'b0;
      end
      case (rts_control)
        `RTS_BY_TX: rts_n_q <= !(rts_manual || (rts_hold_q && !tx_empty));
        `RTS_BY_RX: rts_n_q <= rx_fifo_full;
        default:    rts_n_q <= !rts_manual;
      endcase
      iack_vector_valid_q <= iack && vector_enable;
      iack_vector_q       <= (iack && vector_enable) ? interrupt_vector_reg : 8'h00;
    end
  end
endmodule // uart_channel_baud_irq
`default_nettype wire

// ---- design/uart_channel_defs.vh ----
// Purpose: Shared constants for the serial channel
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef UART_CHANNEL_DEFS_VH
`define UART_CHANNEL_DEFS_VH

// Parity mode codes
`define PAR_EVEN        2'h0
`define PAR_ODD         2'h1
`define PAR_FORCE       2'h2
`define PAR_NONE        2'h3

// Channel mode codes
`define CH_NORMAL       2'h0
`define CH_ECHO         2'h1
`define CH_LOCAL_LOOP   2'h2
`define CH_REMOTE_LOOP  2'h3

// Request-to-send control codes
`define RTS_MANUAL      2'h0
`define RTS_BY_TX       2'h1
`define RTS_BY_RX       2'h2

// Interrupt status bit positions
`define IST_TX_READY    0
`define IST_RX_READY    1
`define IST_BREAK_CHG   2
`define IST_CTS_CHG     3

// Receive word field positions
`define RW_PE           8
`define RW_FE           9
`define RW_RB           10
`define RW_WIDTH        11

// Timing counts
`define PRESCALE_DIV    2
`define X16_PHASES      16
`define X16_MID         4'h7
`define X16_LAST        4'hf
`define FIFO_DEPTH      32

// Reset values
`define RST_LINE        1'b1
`define RST_STATUS      4'h0

`endif

// ---- design/char_fifo.v ----
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: Single clock, DEPTH a power of two
// Notes:   Output data is the head word, registered storage
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire             full
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign full      = (cnt_q == DEPTH);
  assign in_ready  = !full;
  assign out_valid = (cnt_q != 0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // char_fifo
`default_nettype wire

// ---- dv/uart_channel_baud_irq_sva.sv ----
// Purpose: Port assertions for the serial channel
// Assumes: One clock, async high reset
// Notes:   Bound onto the channel top
`timescale 1ns/1ps
`default_nettype none
module uart_channel_baud_irq_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       tx_serial,
  input wire logic       tx_empty,
  input wire logic       send_break,
  input wire logic       ext_x1,
  input wire logic [1:0] channel_mode,
  input wire logic       cts_n,
  input wire logic       overrun_q,
  input wire logic       overrun_clr,
  input wire logic [3:0] interrupt_mask_reg,
  input wire logic [3:0] status_clr,
  input wire logic [3:0] interrupt_status_reg,
  input wire logic       irq_n,
  input wire logic       iack,
  input wire logic       vector_enable,
  input wire logic [7:0] interrupt_vector_reg,
  input wire logic [7:0] iack_vector_q,
  input wire logic       iack_vector_valid_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_IRQ_NOR: assert property (irq_n == ~|(interrupt_status_reg & interrupt_mask_reg))
    else $error("irq_n not NOR of masked status");
  AST_LOCAL_MARK: assert property (channel_mode == 2'h2 && !send_break |-> tx_serial)
    else $error("tx low in local loop");
  AST_IDLE_MARK: assert property (tx_empty && channel_mode == 2'h0 && !send_break
    |-> tx_serial) else $error("tx low while empty");
  AST_BIT_HOLD: assert property ($changed(tx_serial) && channel_mode == 2'h0 && !ext_x1
    |=> $stable(tx_serial) [*8]) else $error("tx bit too short");
  AST_CTS_CHG: assert property ($changed(cts_n) && !status_clr[3]
    |-> ##[1:5] interrupt_status_reg[3]) else $error("cts change not flagged");
  AST_BREAK_STICKY: assert property (interrupt_status_reg[2] && !status_clr[2]
    |=> interrupt_status_reg[2]) else $error("break flag lost");
  AST_OVR_STICKY: assert property (overrun_q && !overrun_clr |=> overrun_q)
    else $error("overrun flag lost");
  AST_VEC: assert property (iack && vector_enable
    |=> iack_vector_valid_q && iack_vector_q == $past(interrupt_vector_reg))
    else $error("vector wrong");
  AST_AUTOVEC: assert property (iack && !vector_enable |=> !iack_vector_valid_q)
    else $error("vector given in autovector mode");
  AST_RST_IDLE: assert property ($fell(rst)
    |-> tx_serial && interrupt_status_reg[3:2] == 2'h0) else $error("not idle after reset");
  cover property (iack && vector_enable);
  cover property ($rose(overrun_q));
  cover property ($fell(irq_n));
endmodule // uart_channel_baud_irq_sva
bind uart_channel_baud_irq uart_channel_baud_irq_sva chk (.clk, .rst, .tx_serial, .tx_empty,
  .send_break, .ext_x1, .channel_mode, .cts_n, .overrun_q, .overrun_clr, .interrupt_mask_reg,
  .status_clr, .interrupt_status_reg, .irq_n, .iack, .vector_enable, .interrupt_vector_reg,
  .iack_vector_q, .iack_vector_valid_q);
`default_nettype wire

// ---- dv/serial_station.sv ----
// Purpose: Remote serial station on the channel pins
// Assumes: 64 system clocks per bit
// Notes:   Ext clock stands low unless ext_run
`timescale 1ns/1ps
`default_nettype none
module serial_station #(
  parameter int BIT = 64
) (
  input  wire logic clk,
  input  wire logic tx_serial,
  input  wire logic ext_run,
  output var  logic rx_serial,
  output var  logic ext_clk
);
  logic [11:0] frame_q;
  int          nsamp;
  int          frames;
  initial begin
    {rx_serial, ext_clk, frame_q} = 14'h2fff;
    nsamp = 10;
    frames = 0;
  end
  // Tick source, 40 ns period
  always #20 ext_clk = ext_run & ~ext_clk;
  // Mid-bit sampler
  always begin
    @(negedge tx_serial);
    frame_q = 12'hfff;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < nsamp; i++) begin
      frame_q[i] = tx_serial;
      if (i < nsamp - 1) repeat (BIT) @(posedge clk);
    end
    frames++;
  end
  // Frame out LSB first, then mark
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1 rx_serial = bits[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    #1 rx_serial = 1'b1;
  endtask
endmodule // serial_station
`default_nettype wire

// ---- dv/uart_channel_baud_irq_tb.sv ----
// Purpose: Self-checking bench for the serial channel
// Assumes: Preload 0 gives 64 clocks per bit
// Notes:   Station model on the serial pins
`timescale 1ns/1ps
`default_nettype none
module uart_channel_baud_irq_tb;
  logic        clk, rst, rx_serial, tx_serial, rts_n_q, cts_n, ext_run, send_break;
  logic        external_timer_input, tx_enable, rx_enable, parity_force_val, cts_enable;
  logic        rts_manual, rx_clk_ext, tx_clk_ext, tx_valid, tx_ready, tx_empty, rx_read;
  logic        rx_ready, rx_fifo_full, overrun_q, overrun_clr, break_active_q, irq_n;
  logic        iack, vector_enable, iack_vector_valid_q;
  logic [1:0]  data_bits_sel, parity_mode, channel_mode, rts_control;
  logic [7:0]  tx_data, rx_data_q, interrupt_vector_reg, iack_vector_q;
  logic [5:0]  stop_len16;
  logic [2:0]  rx_err_q;
  logic [3:0]  interrupt_mask_reg, status_clr, interrupt_status_reg;
  logic [10:0] w;
  int          num_errors = 0;
  int          compares = 0;
  uart_channel_baud_irq dut (.clk, .rst, .rx_serial, .tx_serial, .rts_n_q, .cts_n,
    .external_timer_input, .tx_enable, .rx_enable, .data_bits_sel, .parity_mode,
    .parity_force_val, .multidrop_mode(1'b0), .stop_len16, .stop_two_x1(1'b0), .channel_mode,
    .send_break, .cts_enable, .rts_control, .rts_manual, .rx_clk_ext, .tx_clk_ext,
    .ext_x1(1'b0), .baud_preload_first(8'h00), .baud_preload_second(8'h00), .tx_data,
    .tx_valid, .tx_ready, .tx_empty, .rx_read, .rx_data_q, .rx_err_q, .rx_ready,
    .rx_fifo_full, .overrun_q, .overrun_clr, .break_active_q, .interrupt_mask_reg,
    .status_clr, .interrupt_status_reg, .irq_n, .iack, .vector_enable,
    .interrupt_vector_reg, .iack_vector_q, .iack_vector_valid_q);
  serial_station st (.clk, .tx_serial, .ext_run, .rx_serial, .ext_clk(external_timer_input));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang(input string what);
    num_errors++;
    $display("MISMATCH %s expected done seen timeout", what);
    stop_test();
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; st.frames < n; i++) begin
      if (i > 12000) hang("frame");
      step(1);
    end
  endtask
  task automatic put(input logic [7:0] d);
    for (int i = 0; tx_ready !== 1'b1; i++) begin
      if (i > 12000) hang("tx_ready");
      step(1);
    end
    tx_data = d;
    tx_valid = 1'b1;
    step(1);
    tx_valid = 1'b0;
    step(1);
  endtask
  task automatic get();
    for (int i = 0; rx_ready !== 1'b1; i++) begin
      if (i > 12000) hang("rx_ready");
      step(1);
    end
    rx_read = 1'b1;
    step(1);
    rx_read = 1'b0;
    w = {rx_err_q, rx_data_q};
    step(1);
  endtask
  function automatic logic [11:0] frame(input logic [7:0] d, input int n, input logic [1:0] pm);
    logic [11:0] f;
    logic        p;
    f = 12'hffe;
    p = 1'b0;
    for (int i = 0; i < n; i++) begin
      f[i+1] = d[i];
      p = p ^ d[i];
    end
    if (pm != 2'h3) f[n+1] = (pm == 2'h2) ? parity_force_val : p ^ pm[0];
    return f;
  endfunction
  task automatic t_reset();
    check("tx_serial", 1, tx_serial);
    check("rts_n_q", 1, rts_n_q);
    check("status", 0, interrupt_status_reg);
    check("irq_n", 1, irq_n);
  endtask
  task automatic t_tx();
    tx_enable = 1'b1;
    put(8'ha5);
    put(8'h3c);
    wait_frames(1);
    check("frame a5", frame(8'ha5, 8, 2'h3), st.frame_q);
    wait_frames(2);
    check("frame 3c", frame(8'h3c, 8, 2'h3), st.frame_q);
    step(80);
    check("tx_empty", 1, tx_empty);
    check("idle line", 1, tx_serial);
  endtask
  task automatic t_fmt();
    for (int k = 0; k < 4; k++) begin
      {data_bits_sel, parity_mode} = {2'(k), 2'(k)};
      stop_len16 = k[0] ? 6'h20 : 6'h10;
      st.nsamp = k + 7 + (k != 3);
      put(8'hd6);
      wait_frames(st.frames + 1);
      check("format", frame(8'hd6, k + 5, 2'(k)), st.frame_q);
      step(150);
    end
  endtask
  task automatic t_rx();
    logic [11:0] bits [4] = '{12'h4b4, 12'h6b4, 12'h0b4, 12'h000};
    logic [10:0] want [4] = '{11'h05a, 11'h15a, 11'h25a, 11'h600};
    {data_bits_sel, parity_mode} = 4'hc;
    rx_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      st.send(bits[i], 11);
      get();
      check("rx word", want[i], w);
    end
    check("break flag", 1, interrupt_status_reg[2]);
    step(64);
    status_clr = 4'h4;
    step(1);
    status_clr = 4'h0;
    check("break clear", 0, interrupt_status_reg[2]);
  endtask
  task automatic t_fifo();
    rts_control = 2'h2;
    {data_bits_sel, parity_mode} = 4'hf;
    for (int i = 0; i < 33; i++) begin
      st.send({1'b1, 8'(i), 1'b0}, 10);
      if (i == 31) check("fifo full", 1, rx_fifo_full);
    end
    check("overrun", 1, overrun_q);
    check("rts by rx", 1, rts_n_q);
    for (int i = 0; i < 32; i++) begin
      get();
      check("fifo order", i, w);
    end
    check("fifo empty", 0, rx_ready);
    overrun_clr = 1'b1;
    step(1);
    overrun_clr = 1'b0;
    check("overrun clear", 0, overrun_q);
    rts_control = 2'h0;
  endtask
  task automatic t_irq();
    int f0;
    rts_manual = 1'b1;
    status_clr = 4'h8;
    step(2);
    status_clr = 4'h0;
    check("rts manual", 0, rts_n_q);
    check("cts quiet", 0, interrupt_status_reg[3]);
    cts_n = 1'b1;
    step(6);
    check("cts change", 1, interrupt_status_reg[3]);
    interrupt_mask_reg = 4'h8;
    step(1);
    check("irq unmasked", 0, irq_n);
    interrupt_mask_reg = 4'h4;
    step(1);
    check("irq masked", 1, irq_n);
    status_clr = 4'h8;
    step(1);
    status_clr = 4'h0;
    check("cts clear", 0, interrupt_status_reg[3]);
    cts_enable = 1'b1;
    f0 = st.frames;
    put(8'h81);
    step(300);
    check("cts hold", f0, st.frames);
    cts_n = 1'b0;
    wait_frames(f0 + 1);
    check("cts frame", frame(8'h81, 8, 2'h3), st.frame_q);
    interrupt_vector_reg = 8'h4c;
    {iack, vector_enable} = 2'h3;
    step(1);
    check("vector", 12'h14c, {iack_vector_valid_q, iack_vector_q});
    {iack, vector_enable} = 2'h0;
    step(1);
    iack = 1'b1;
    step(1);
    iack = 1'b0;
    check("autovector", 0, iack_vector_valid_q);
    cts_enable = 1'b0;
  endtask
  task automatic t_modes();
    int f0;
    f0 = st.frames;
    channel_mode = 2'h2;
    put(8'h69);
    get();
    check("local loop", 11'h069, w);
    check("loop line", f0, st.frames);
    channel_mode = 2'h0;
    send_break = 1'b1;
    step(20);
    check("break out", 0, tx_serial);
    send_break = 1'b0;
    step(700);
    f0 = st.frames;
    tx_clk_ext = 1'b1;
    put(8'h2d);
    step(300);
    check("no ext clock", f0, st.frames);
    ext_run = 1'b1;
    wait_frames(f0 + 1);
    check("ext frame", frame(8'h2d, 8, 2'h3), st.frame_q);
    rx_clk_ext = 1'b1;
    st.send(12'h2e6, 10);
    get();
    check("ext rx", 11'h073, w);
    ext_run = 1'b0;
  endtask
  initial begin
    {rst, tx_enable, rx_enable, cts_enable, rts_manual, rx_clk_ext, tx_clk_ext} = 7'h40;
    {cts_n, ext_run, tx_valid, rx_read, overrun_clr, iack, vector_enable} = 7'h00;
    {data_bits_sel, parity_mode, channel_mode, rts_control} = 8'hf0;
    {tx_data, interrupt_vector_reg, interrupt_mask_reg, status_clr} = 24'h00_0000;
    {send_break, parity_force_val, stop_len16} = 8'h50;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    step(2);
    t_reset();
    t_tx();
    t_fmt();
    t_rx();
    t_fifo();
    t_irq();
    t_modes();
    stop_test();
  end
endmodule // uart_channel_baud_irq_tb
`default_nettype wire
